/* File: host_model.sv */
// remote host model: command pulses and queries
`timescale 1ns/1ps
module host_model
   import opstat_pkg::*;
(
   input wire logic clk_sys,
   input wire logic answer_valid,
   input wire logic [15:0] answer_data,
   output logic [4:0] wr,
   output logic [15:0] val,
   output query_t query_sel,
   output logic query_strobe
);
   initial
   begin
      wr = 5'h00;
      val = 16'h0000;
      query_strobe = 1'b0;
      query_sel = Q_NONE;
   end
   // k: 0 limit, 1 setpoint, 2 current, 3 clear, 4 mask
   task automatic cmd(input int k, input logic [15:0] v);
      @(negedge clk_sys);
      wr[k] = 1'b1;
      val = (k == 4) ? (v & OP_DEFINED_MASK) : v;
      @(negedge clk_sys);
      wr = 5'h00;
      val = ~val;
   endtask : cmd
   task automatic ask(input query_t q, output logic [15:0] d, output logic v);
      @(negedge clk_sys);
      query_strobe = 1'b1;
      query_sel = q;
      @(negedge clk_sys);
      query_strobe = 1'b0;
      d = answer_data;
      v = answer_valid;
   endtask : ask
endmodule : host_model

/* File: operation_status_and_ov_flag.sv */
// module: operation status bank, voltage limit and overvoltage flag
`timescale 1ns/1ps

// Behaviour
// - hold upper voltage limit; setpoint writes above it are clamped to it
// - over-limit setpoint write posts error code -301
// - limit query returns the most recently written limit
// - overvoltage clear forces voltage setpoint zero, current limit near one percent
// - overvoltage clear resets the tripped flag so trip query reads zero, except when a trip edge lands in the same cycle
// - trip query returns a single bit value, zero or one
// - trip query reads one while tripped, zero otherwise
// - mode query returns distinct tokens for voltage and current regulation
// - condition register shows live conditions, unlatched
// - bit 10 current regulation, bit 8 voltage regulation, unused bits zero
// - bit 5 waiting for trigger, from trigger subsystem
// - bit 0 calibration constants being computed
// - writable enable mask gates event bits into the summary
// - status byte bit 7 is OR of enabled event bits
// - mask query returns the written mask with bits outside OP_DEFINED_MASK cleared
// - event register is read-only and latches condition changes until read
// - event read returns contents then clears them
// - each event bit records a change since the previous event read
module operation_status_and_ov_flag
   import opstat_pkg::*;
#(
   parameter int unsigned FULL_SCALE_I = 16'd1000
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic cal_busy,
   input wire logic trigger_wait,
   input wire logic in_current_mode,
   input wire logic ov_trip_event,
   input wire logic vlim_write,
   input wire logic [SET_W-1:0] vlim_value,
   input wire logic vset_write,
   input wire logic [SET_W-1:0] vset_value,
   input wire logic iset_write,
   input wire logic [SET_W-1:0] iset_value,
   input wire logic ov_clear,
   input wire logic mask_write,
   input wire logic [15:0] mask_value,
   input wire logic query_strobe,
   input wire query_t query_sel,
   output logic answer_valid,
   output logic [15:0] answer_data,
   output logic [SET_W-1:0] vset_q,
   output logic [SET_W-1:0] iset_q,
   output logic err_post,
   output logic signed [15:0] err_code,
   output logic op_summary_q
);

   // ------------------------------------------------------------
   // live inputs synchronised
   // ------------------------------------------------------------
   logic [3:0] pin_raw;
   logic [3:0] pin_sync_q;
   op_live_t live;
   logic ov_sync;
   logic ov_prev_q;
   logic ov_rise;
   logic ov_tripped_q;
   logic [SET_W-1:0] vlim_q;
   logic [15:0] cond;
   logic [15:0] cond_prev_q;
   logic [15:0] op_mask_q;
   logic [15:0] op_event_q;
   logic [15:0] op_event_d;
   logic [15:0] change;
   logic event_read;
   answer_t ans_q;
   answer_t ans_d;
   logic [SET_W-1:0] iset_clear;
   logic vset_over;

   // four level pins share one two-stage synchroniser
   assign pin_raw = {cal_busy, trigger_wait, in_current_mode, ov_trip_event};

   pin_sync #(
      .W(4)
   ) u_pin_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin_async(pin_raw),
      .pin_sync_q(pin_sync_q)
   );

   // mode decoded only after the second stage
   always_comb
   begin
      live.cal_busy = pin_sync_q[3];
      live.trigger_wait_flag = pin_sync_q[2];
      live.voltage_regulation_flag = ~pin_sync_q[1];
      live.current_regulation_flag = pin_sync_q[1];
   end

   assign ov_sync = pin_sync_q[0];
   assign ov_rise = ov_sync && !ov_prev_q;

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         ov_prev_q <= 1'b0;
      else
         ov_prev_q <= ov_sync;
   end

   // ------------------------------------------------------------
   // condition register
   // ------------------------------------------------------------
   always_comb
   begin
      cond = 16'h0000;
      cond[CAL_BIT] = live.cal_busy;
      cond[TRIG_WAIT_POS] = live.trigger_wait_flag;
      cond[CVR_POS] = live.voltage_regulation_flag;
      cond[CCR_POS] = live.current_regulation_flag;
   end

   assign change = cond ^ cond_prev_q;
   assign event_read = query_strobe && (query_sel == Q_EVENT);

   // ------------------------------------------------------------
   // event latch, mask and summary
   // ------------------------------------------------------------
   // history tracks through reset, so release raises no false change
   always_ff @(posedge clk_sys)
   begin
      cond_prev_q <= cond;
   end

   // a change landing on the clearing read is kept for the next read
   always_comb
   begin
      if (event_read)
         op_event_d = change;
      else
         op_event_d = op_event_q | change;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         op_event_q <= OP_EVENT_RESET;
      else
         op_event_q <= op_event_d;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         op_mask_q <= OP_MASK_RESET;
      else if (mask_write)
         op_mask_q <= mask_value & OP_DEFINED_MASK;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         op_summary_q <= 1'b0;
      else
         op_summary_q <= |(op_event_q & op_mask_q);
   end

   // ------------------------------------------------------------
   // voltage limit, setpoints and error posting
   // ------------------------------------------------------------
   assign iset_clear = SET_W'((FULL_SCALE_I * ISET_CLEAR_PCT + 99) / 100);
   assign vset_over = (vset_value > vlim_q);

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         vlim_q <= VLIM_RESET;
      else if (vlim_write)
         vlim_q <= vlim_value;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         vset_q <= VSET_RESET;
         iset_q <= ISET_RESET;
         err_post <= 1'b0;
         err_code <= ERR_CODE_RESET;
      end
      else
      begin
         err_post <= 1'b0;
         // clear wins over a setpoint or current write in the same cycle
         if (ov_clear)
         begin
            vset_q <= VSET_RESET;
            iset_q <= iset_clear;
         end
         else
         begin
            if (vset_write)
            begin
               if (vset_over)
               begin
                  vset_q <= vlim_q;
                  err_post <= 1'b1;
                  err_code <= ERR_OUT_OF_RANGE;
               end
               else
                  vset_q <= vset_value;
            end
            if (iset_write)
               iset_q <= iset_value;
         end
      end
   end

   // ------------------------------------------------------------
   // overvoltage tripped flag
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         ov_tripped_q <= 1'b0;
      // a trip edge wins over a clear in the same cycle
      else if (ov_rise)
         ov_tripped_q <= 1'b1;
      else if (ov_clear)
         ov_tripped_q <= 1'b0;
   end

   // ------------------------------------------------------------
   // query answers, one cycle after the strobe
   // ------------------------------------------------------------
   always_comb
   begin
      ans_d = ans_q;
      ans_d.valid = query_strobe && (query_sel != Q_NONE);
      if (query_strobe)
      begin
         unique case (query_sel)
            Q_COND: ans_d.data = cond;
            Q_MASK: ans_d.data = op_mask_q;
            Q_EVENT: ans_d.data = op_event_q;
            Q_TRIP: ans_d.data = {15'h0, ov_tripped_q};
            Q_MODE: ans_d.data = live.current_regulation_flag ?
                                 MODE_TOKEN_CURR : MODE_TOKEN_VOLT;
            Q_VLIM: ans_d.data = vlim_q;
            default: ans_d.data = ANSWER_DATA_RESET;
         endcase
      end
   end

   // answer data holds until the next query
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         ans_q.valid <= 1'b0;
         ans_q.data <= ANSWER_DATA_RESET;
      end
      else
         ans_q <= ans_d;
   end

   assign answer_valid = ans_q.valid;
   assign answer_data = ans_q.data;

endmodule : operation_status_and_ov_flag

// ------------------------------------------------------------
// two-stage synchroniser for level pins
// ------------------------------------------------------------
module pin_sync
   import opstat_pkg::*;
#(
   parameter int unsigned W = 1
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [W-1:0] pin_async,
   output logic [W-1:0] pin_sync_q
);

   // only the second stage is read by any logic
   logic [W-1:0] pin_meta_q;

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
      end
      else
      begin
         pin_meta_q <= pin_async;
         pin_sync_q <= pin_meta_q;
      end
   end

endmodule : pin_sync

/* File: opstat_chk.sv */
// checker for the operation status bank
`timescale 1ns/1ps
module opstat_chk
   import opstat_pkg::*;
#(
   parameter int unsigned FULL_SCALE_I = 1000
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic vlim_write,
   input wire logic [SET_W-1:0] vlim_value,
   input wire logic vset_write,
   input wire logic [SET_W-1:0] vset_value,
   input wire logic ov_clear,
   input wire logic mask_write,
   input wire logic [15:0] mask_value,
   input wire logic query_strobe,
   input wire query_t query_sel,
   input wire logic answer_valid,
   input wire logic [15:0] answer_data,
   input wire logic [SET_W-1:0] vset_q,
   input wire logic [SET_W-1:0] iset_q,
   input wire logic err_post,
   input wire logic signed [15:0] err_code,
   input wire logic op_summary_q
);
   localparam logic [15:0] ISET_LOW = 16'((FULL_SCALE_I + 99) / 100);
   logic [15:0] lim_h;
   logic [15:0] mask_h;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         lim_h <= VLIM_RESET;
         mask_h <= OP_MASK_RESET;
      end
      else
      begin
         if (vlim_write)
            lim_h <= vlim_value;
         if (mask_write)
            mask_h <= mask_value & OP_DEFINED_MASK;
      end
   end
   a_answer_follows: assert property (query_strobe && query_sel != Q_NONE |=> answer_valid)
      else $error("answer missing");
   a_clamp_error: assert property (vset_write && !ov_clear && !vlim_write && vset_value > lim_h
      |=> vset_q == lim_h && err_post && err_code == ERR_OUT_OF_RANGE) else $error("no clamp");
   a_setpoint_kept: assert property (vset_write && !ov_clear && vset_value <= lim_h
      |=> vset_q == $past(vset_value) && !err_post) else $error("setpoint wrong");
   a_clear_forces: assert property (ov_clear |=> vset_q == 16'h0000 && iset_q == ISET_LOW)
      else $error("clear values wrong");
   a_trip_single: assert property (query_strobe && query_sel == Q_TRIP |=> answer_data[15:1] == 15'h0)
      else $error("trip not binary");
   a_cond_unused: assert property (query_strobe && query_sel == Q_COND
      |=> (answer_data & ~OP_DEFINED_MASK) == 16'h0000) else $error("unused bit set");
   a_mask_echo: assert property (query_strobe && query_sel == Q_MASK && !mask_write
      |=> answer_data == mask_h) else $error("mask answer wrong");
   a_summary_masked: assert property ($past(mask_h) == 16'h0000 |-> !op_summary_q)
      else $error("summary without mask");
   c_clamp: cover property (vset_write && vset_value > lim_h);
   c_clear: cover property (ov_clear);
   c_summary: cover property (op_summary_q);
endmodule : opstat_chk

bind operation_status_and_ov_flag opstat_chk #(.FULL_SCALE_I(FULL_SCALE_I)) u_chk (.clk_sys, .rst,
   .vlim_write, .vlim_value, .vset_write, .vset_value, .ov_clear, .mask_write, .mask_value,
   .query_strobe, .query_sel, .answer_valid, .answer_data, .vset_q, .iset_q, .err_post,
   .err_code, .op_summary_q);

/* File: opstat_pkg.sv */
// package: constants and types for the operation status bank
package opstat_pkg;

   // ------------------------------------------------------------
   // operation register bit positions
   // ------------------------------------------------------------
   localparam int unsigned CAL_BIT = 0;
   localparam int unsigned TRIG_WAIT_POS = 5;
   localparam int unsigned CVR_POS = 8;
   localparam int unsigned CCR_POS = 10;
   localparam logic [15:0] OP_DEFINED_MASK = 16'h0521;
   localparam logic [15:0] OP_MASK_RESET = 16'h0000;
   localparam logic [15:0] OP_EVENT_RESET = 16'h0000;

   // ------------------------------------------------------------
   // setpoints and error code
   // ------------------------------------------------------------
   localparam int unsigned SET_W = 16;
   localparam logic [SET_W-1:0] VLIM_RESET = 16'hffff;
   localparam logic [SET_W-1:0] VSET_RESET = 16'h0000;
   localparam logic [SET_W-1:0] ISET_RESET = 16'h0000;
   localparam int unsigned ISET_CLEAR_PCT = 1;
   localparam logic signed [15:0] ERR_OUT_OF_RANGE = -16'sd301;
   localparam logic signed [15:0] ERR_CODE_RESET = 16'sh0000;
   localparam logic [15:0] ANSWER_DATA_RESET = 16'h0000;

   // ------------------------------------------------------------
   // query selector and answer tokens
   // ------------------------------------------------------------
   typedef enum logic [6:0] {
      Q_NONE = 7'b0000001,
      Q_COND = 7'b0000010,
      Q_MASK = 7'b0000100,
      Q_EVENT = 7'b0001000,
      Q_TRIP = 7'b0010000,
      Q_MODE = 7'b0100000,
      Q_VLIM = 7'b1000000
   } query_t;

   localparam logic [15:0] MODE_TOKEN_VOLT = 16'h0000;
   localparam logic [15:0] MODE_TOKEN_CURR = 16'h0001;

   typedef struct packed {
      logic cal_busy;
      logic trigger_wait_flag;
      logic voltage_regulation_flag;
      logic current_regulation_flag;
   } op_live_t;

   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } answer_t;

endpackage : opstat_pkg

/* File: tb.sv */
// testbench for the operation status bank
`timescale 1ns/1ps
module tb;
   import opstat_pkg::*;
   logic clk_sys, rst, cal_busy, trigger_wait, in_current_mode, ov_trip_event;
   logic answer_valid, err_post, op_summary_q, query_strobe, ok;
   logic [4:0] wr;
   logic [15:0] val, answer_data, vset_q, iset_q, d, lfsr_q, lim, v;
   logic signed [15:0] err_code;
   query_t query_sel;
   int mismatches, total_checks;
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   host_model host (.clk_sys, .answer_valid, .answer_data, .wr, .val, .query_sel, .query_strobe);
   operation_status_and_ov_flag #(.FULL_SCALE_I(1000)) dut (.clk_sys, .rst, .cal_busy,
      .trigger_wait, .in_current_mode, .ov_trip_event, .vlim_write(wr[0]), .vlim_value(val),
      .vset_write(wr[1]), .vset_value(val), .iset_write(wr[2]), .iset_value(val),
      .ov_clear(wr[3]), .mask_write(wr[4]), .mask_value(val), .query_strobe, .query_sel,
      .answer_valid, .answer_data, .vset_q, .iset_q, .err_post, .err_code, .op_summary_q);
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic logic [15:0] exp_cond(input logic c, input logic w, input logic i);
      return {5'h0, i, 1'b0, ~i, 2'h0, w, 4'h0, c};
   endfunction : exp_cond
   function automatic logic [15:0] exp_vset(input logic [15:0] req, input logic [15:0] top);
      return (req > top) ? top : req;
   endfunction : exp_vset
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      total_checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic live(input logic c, input logic w, input logic i);
      @(negedge clk_sys);
      cal_busy = c;
      trigger_wait = w;
      in_current_mode = i;
      repeat (5) @(negedge clk_sys);
   endtask : live
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : give_verdict
   initial
   begin
      repeat (4000) @(posedge clk_sys);
      mismatches++;
      give_verdict();
   end
   initial
   begin
      {cal_busy, trigger_wait, in_current_mode, ov_trip_event} = 4'h0;
      mismatches = 0;
      total_checks = 0;
      lfsr_q = 16'h0051;
      rst = 1'b1;
      repeat (6) @(negedge clk_sys);
      rst = 1'b0;
      host.ask(Q_MASK, d, ok);
      chk("mask reset", d, OP_MASK_RESET);
      for (int k = 0; k < 12; k++)
      begin
         lfsr_q = lfsr(lfsr_q);
         lim = (k == 0) ? 16'h0005 : lfsr_q;
         v = (k == 0) ? 16'h0021 : lfsr(lfsr_q);
         host.cmd(0, lim);
         host.ask(Q_VLIM, d, ok);
         chk("limit", d, lim);
         host.cmd(1, v);
         chk("error flag", {15'h0, err_post}, {15'h0, v > lim});
         chk("setpoint", vset_q, exp_vset(v, lim));
      end
      chk("error code", err_code, ERR_OUT_OF_RANGE);
      $display("test limit done");
      ov_trip_event = 1'b1;
      repeat (5) @(negedge clk_sys);
      host.ask(Q_TRIP, d, ok);
      chk("trip set", d, 16'h0001);
      chk("answer valid", {15'h0, ok}, 16'h0001);
      host.cmd(2, lfsr_q);
      chk("current", iset_q, lfsr_q);
      host.cmd(3, 16'h0000);
      chk("clear setpoint", vset_q, 16'h0000);
      chk("clear current", iset_q, 16'h000a);
      host.ask(Q_TRIP, d, ok);
      chk("trip cleared", d, 16'h0000);
      $display("test trip done");
      for (int k = 0; k < 8; k++)
      begin
         lfsr_q = lfsr(lfsr_q);
         live(lfsr_q[0], lfsr_q[1], k[0]);
         host.ask(Q_COND, d, ok);
         chk("condition", d, exp_cond(lfsr_q[0], lfsr_q[1], k[0]));
         host.ask(Q_MODE, d, ok);
         chk("mode", d, k[0] ? MODE_TOKEN_CURR : MODE_TOKEN_VOLT);
      end
      $display("test condition done");
      live(1'b0, 1'b0, 1'b0);
      host.cmd(4, 16'h0521);
      host.ask(Q_EVENT, d, ok);
      host.ask(Q_EVENT, d, ok);
      chk("event cleared", d, 16'h0000);
      chk("summary idle", {15'h0, op_summary_q}, 16'h0000);
      host.ask(Q_MASK, d, ok);
      chk("mask", d, 16'h0521);
      live(1'b1, 1'b1, 1'b1);
      chk("summary set", {15'h0, op_summary_q}, 16'h0001);
      host.ask(Q_EVENT, d, ok);
      chk("event", d, 16'h0521);
      @(negedge clk_sys);
      chk("summary drop", {15'h0, op_summary_q}, 16'h0000);
      host.cmd(4, 16'h0400);
      live(1'b1, 1'b0, 1'b1);
      chk("summary masked", {15'h0, op_summary_q}, 16'h0000);
      host.ask(Q_EVENT, d, ok);
      chk("event held", d, 16'h0020);
      @(negedge clk_sys);
      cal_busy = 1'b0;
      @(negedge clk_sys);
      host.ask(Q_EVENT, d, ok);
      chk("event during read", d, 16'h0000);
      host.ask(Q_EVENT, d, ok);
      chk("event kept", d, 16'h0001);
      $display("test event done");
      give_verdict();
   end
endmodule : tb
